//--- scp_parser.v
// serial command parser with addressed framing and crc-7 check
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.vh"
module scp_parser (
  input wire sys_clk_in,
  input wire srst_in,
  input wire [7:0] rx_byte_in,
  input wire rx_valid_in,
  input wire crc_enable_in,
  input wire serial_mode_in,
  input wire brake_when_off_in,
  input wire dev_num_load_in,
  input wire [6:0] dev_num_in,
  input wire err_clear_in,
  input wire [15:0] err_clear_mask_in,
  output reg [11:0] target_out,
  output reg target_load_out,
  output reg motor_enable_out,
  output reg motor_brake_out,
  output reg [15:0] err_flags_out,
  output reg [6:0] dev_num_out
);
  // ****************************************
  // timing and limitations
  // ****************************************
  // a byte acts on the third edge after its valid level rises:
  // two synchroniser stages, then the edge-detect strobe
  // the byte word crosses without gray code; safe only because
  // the host holds it steady two edges before valid and while high
  // valid low at no clock edge merges two bytes into one
  // crc mode is read per byte; flipping it inside a packet
  // spoils that packet only, the next command byte recovers
  // a new device number applies from the next address byte
  // awaiting flag ignores the clear mask: only a target lifts it
  // foreign packets are tracked to the end so their data and
  // crc bytes are never taken as a command of our own
  // unknown addressed codes skip to the next command byte,
  // since their length is not known here
  // trade-off: a bit-serial crc would save gates but cost
  // eight edges per byte; the unrolled loop keeps one edge

  // ****************************************
  // parser states
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CODE = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_CRC = 3'h4;
  localparam ST_SKIP = 3'h5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [6:0] crc;
  reg [6:0] next_crc;
  reg [6:0] code;
  reg [6:0] next_code;
  reg [6:0] hi;
  reg [6:0] next_hi;
  reg foreign;
  reg next_foreign;
  reg exec;
  reg bad_crc;
  reg proto;
  reg [7:0] rx_sync1;
  reg [7:0] rx_sync2;
  reg vld_sync1;
  reg vld_sync2;
  reg vld_seen;
  wire [6:0] crc_c;
  wire [6:0] crc_b;
  wire byte_stb;
  wire is_cmd;
  wire is_addr_start;
  wire is_off_code;
  wire is_hires_code;

  // ****************************************
  // input synchronisers
  // ****************************************
  // byte arrives from outside the clock domain, so two stages first
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rx_sync1 <= 8'h00;
      rx_sync2 <= 8'h00;
      vld_sync1 <= 1'b0;
      vld_sync2 <= 1'b0;
      vld_seen <= 1'b0;
    end
    else
    begin
      rx_sync1 <= rx_byte_in;
      rx_sync2 <= rx_sync1;
      vld_sync1 <= rx_valid_in;
      vld_sync2 <= vld_sync1;
      vld_seen <= vld_sync2;
    end
  end

  // one strobe per rising edge of the valid level
  assign byte_stb = vld_sync2 & ~vld_seen;
  assign is_cmd = rx_sync2[7];

  // ****************************************
  // command decode
  // ****************************************
  // the same low seven bits decode a short code and an addressed code
  assign is_addr_start = (rx_sync2 == `SCP_ADDR_START);
  assign is_off_code = (rx_sync2[6:0] == `SCP_CMD_MOTOR_OFF);
  assign is_hires_code = ((rx_sync2[6:0] & `SCP_CMD_HIRES_MASK) == `SCP_CMD_HIRES_CODE);

  // ****************************************
  // crc-7 byte update
  // ****************************************
  // bitwise lsb-first division of one byte into the running remainder
  scp_crc7_step #(
    .POLY(`SCP_CRC_POLY_REFL)
  ) u_crc_run (
    .crc_in(crc),
    .byte_in(rx_sync2),
    .crc_out(crc_b)
  );

  // same step started from zero, for the first byte of a packet
  scp_crc7_step #(
    .POLY(`SCP_CRC_POLY_REFL)
  ) u_crc_first (
    .crc_in(7'h00),
    .byte_in(rx_sync2),
    .crc_out(crc_c)
  );

  // ****************************************
  // packet state machine
  // ****************************************
  // the decode of a code byte happens wherever it lands (short or addressed)
  always @*
  begin
    next_state = state;
    next_crc = crc;
    next_code = code;
    next_hi = hi;
    next_foreign = foreign;
    exec = 1'b0;
    bad_crc = 1'b0;
    proto = 1'b0;
    if (byte_stb)
    begin
      if (is_cmd)
      begin
        // any command byte restarts; an open own packet counts as interrupted, except a skip with crc off
        if (state != ST_IDLE && !(state == ST_SKIP && !crc_enable_in))
          proto = ~foreign;
        next_crc = crc_c;
        next_foreign = 1'b0;
        next_state = ST_IDLE;
        if (is_addr_start)
          next_state = ST_ADDR;
        else
        begin
          next_code = rx_sync2[6:0];
          if (is_off_code)
            next_state = crc_enable_in ? ST_CRC : ST_IDLE;
          else if (is_hires_code)
            next_state = ST_DATA;
          else
            proto = 1'b1;
          if (is_off_code && !crc_enable_in)
            exec = 1'b1;
        end
      end
      else
      begin
        next_crc = crc_b;
        case (state)
          ST_ADDR:
          begin
            next_foreign = (rx_sync2[6:0] != dev_num_out);
            next_state = ST_CODE;
          end
          ST_CODE:
          begin
            next_code = rx_sync2[6:0];
            if (is_off_code)
            begin
              next_state = crc_enable_in ? ST_CRC : ST_IDLE;
              exec = ~crc_enable_in & ~foreign;
            end
            else if (is_hires_code)
              next_state = ST_DATA;
            else
            begin
              // other codes: skip to the next command byte, flagging proto unless the packet is foreign
              next_state = ST_SKIP;
              proto = ~foreign;
            end
          end
          ST_DATA:
          begin
            next_hi = rx_sync2[6:0];
            next_state = crc_enable_in ? ST_CRC : ST_IDLE;
            exec = ~crc_enable_in & ~foreign;
          end
          ST_CRC:
          begin
            next_state = ST_IDLE;
            if (rx_sync2[6:0] != crc)
              bad_crc = ~foreign;
            else
              exec = ~foreign;
          end
          ST_SKIP:
            next_state = ST_SKIP;
          default:
            next_state = ST_IDLE; // stray data byte is dropped
        endcase
      end
    end
  end

  // ****************************************
  // registers and outputs
  // ****************************************
  // set beats clear on the error word; no response path so no crc appended
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state <= ST_IDLE;
      crc <= 7'h00;
      code <= 7'h00;
      hi <= 7'h00;
      foreign <= 1'b0;
      target_out <= 12'h000;
      target_load_out <= 1'b0;
      motor_enable_out <= 1'b0;
      motor_brake_out <= 1'b0;
      err_flags_out <= 16'h0001; // motor held off until a target arrives
      dev_num_out <= `SCP_DEV_NUM_RESET;
    end
    else
    begin
      state <= next_state;
      crc <= next_crc;
      code <= next_code;
      hi <= next_hi;
      foreign <= next_foreign;
      if (dev_num_load_in)
        dev_num_out <= dev_num_in;
      target_load_out <= 1'b0;
      // the awaiting flag follows commands in every input mode; the target loads only in serial mode
      if (exec && next_code == `SCP_CMD_MOTOR_OFF)
        err_flags_out[`SCP_ERR_AWAIT_BIT] <= 1'b1;
      else if (exec)
      begin
        err_flags_out[`SCP_ERR_AWAIT_BIT] <= 1'b0;
        if (serial_mode_in)
        begin
          target_out <= {next_hi, next_code[4:0]};
          target_load_out <= 1'b1;
        end
      end
      // no clear path for awaiting: only a target command lifts the hold
      if (bad_crc)
        err_flags_out[`SCP_ERR_CRC_BIT] <= 1'b1;
      else if (err_clear_in && err_clear_mask_in[`SCP_ERR_CRC_BIT])
        err_flags_out[`SCP_ERR_CRC_BIT] <= 1'b0;
      if (proto)
        err_flags_out[`SCP_ERR_PROTO_BIT] <= 1'b1;
      else if (err_clear_in && err_clear_mask_in[`SCP_ERR_PROTO_BIT])
        err_flags_out[`SCP_ERR_PROTO_BIT] <= 1'b0;
      motor_enable_out <= ~next_awaiting(exec, next_code, err_flags_out[0]);
      motor_brake_out <= brake_when_off_in & next_awaiting(exec, next_code,
        err_flags_out[0]);
    end
  end

  // awaiting flag value after this cycle, for the motor outputs
  function next_awaiting;
    input ex;
    input [6:0] cd;
    input cur;
    begin
      if (ex)
        next_awaiting = (cd == `SCP_CMD_MOTOR_OFF);
      else
        next_awaiting = cur;
    end
  endfunction
endmodule // scp_parser

// ****************************************
// crc-7 byte step
// ****************************************
// one byte folded lsb first into a running remainder; kept small so
// the packet start and the running update share one description
module scp_crc7_step #(
  parameter [6:0] POLY = `SCP_CRC_POLY_REFL
) (
  input wire [6:0] crc_in,
  input wire [7:0] byte_in,
  output reg [6:0] crc_out
);
  integer k;

  // a one leaving the bottom folds the reflected generator back in
  always @*
  begin
    crc_out = crc_in;
    for (k = 0; k < 8; k = k + 1)
    begin
      if (crc_out[0] ^ byte_in[k])
        crc_out = (crc_out >> 1) ^ POLY;
      else
        crc_out = crc_out >> 1;
    end
  end
endmodule // scp_crc7_step
`default_nettype wire

//--- scp_map.vh
// constants for the serial command parser
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
`define SCP_ADDR_START 8'hAA
`define SCP_DEV_NUM_RESET 7'h0B
`define SCP_CMD_MOTOR_OFF 7'h7F
`define SCP_CMD_HIRES_MASK 7'h60
`define SCP_CMD_HIRES_CODE 7'h40
`define SCP_CRC_POLY_REFL 7'h48
`define SCP_ERR_AWAIT_BIT 0
`define SCP_ERR_CRC_BIT 10
`define SCP_ERR_PROTO_BIT 11
`endif

//--- scp_parser_sva.sv
// port checks for the serial command parser
`timescale 1ns/10ps
`default_nettype none
module scp_parser_sva (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  input wire logic crc_enable_in,
  input wire logic serial_mode_in,
  input wire logic brake_when_off_in,
  input wire logic dev_num_load_in,
  input wire logic [6:0] dev_num_in,
  input wire logic err_clear_in,
  input wire logic [15:0] err_clear_mask_in,
  input wire logic [11:0] target_out,
  input wire logic target_load_out,
  input wire logic motor_enable_out,
  input wire logic motor_brake_out,
  input wire logic [15:0] err_flags_out,
  input wire logic [6:0] dev_num_out
);
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic [3:0] since = 4'hF;
  // cycles since the last rise of rx_valid_in; saturates so it never wraps into range
  always @(posedge sys_clk_in)
    since <= $rose(rx_valid_in) ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
  sequence s_await;
    err_flags_out[0] [*2];
  endsequence
  sequence s_running;
    !err_flags_out[0] [*2];
  endsequence
  a_load_clears_await: assert property (target_load_out |-> !err_flags_out[0] ##1 !target_load_out) else $error("load pulse wrong");
  a_target_on_load: assert property ($changed(target_out) |-> target_load_out) else $error("target moved without load");
  a_load_serial_only: assert property (target_load_out |-> $past(serial_mode_in)) else $error("load outside serial mode");
  a_motor_runs: assert property (s_running |-> motor_enable_out) else $error("motor not enabled");
  a_motor_stops: assert property (s_await |-> !motor_enable_out) else $error("motor not stopped");
  a_brake_select: assert property (s_await and $stable(brake_when_off_in) [*2] |-> motor_brake_out == brake_when_off_in) else $error("brake mode wrong");
  a_reserved_zero: assert property ((err_flags_out & 16'hF3FE) == 16'h0) else $error("reserved flag set");
  a_dev_num_load: assert property (dev_num_load_in |=> dev_num_out == $past(dev_num_in)) else $error("device number not loaded");
  a_act_after_byte: assert property (target_load_out || $rose(err_flags_out[0]) |-> since >= 4'h1 && since <= 4'h7) else $error("action without byte");
endmodule // scp_parser_sva
`default_nettype wire

//--- scp_host.sv
// host model delivering command bytes to the parser
`timescale 1ns/10ps
`default_nettype none
module scp_host (
  input wire logic sys_clk_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out
);
  // ****
  // byte delivery
  // ****
  initial
  begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
  end
  // data settles two cycles before the strobe and stays while it is high
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk_in);
    #1 rx_byte_out = b;
    repeat (2) @(posedge sys_clk_in);
    #1 rx_valid_out = 1'b1;
    repeat (3) @(posedge sys_clk_in);
    #1 rx_valid_out = 1'b0;
    rx_byte_out = ~b; // stale data must not look valid
  endtask
endmodule // scp_host
`default_nettype wire

//--- scp_parser_tb.sv
// self-checking bench for the serial command parser
`timescale 1ns/10ps
`default_nettype none
module scp_parser_tb;
  // ****
  // bench
  // ****
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic crc_enable_in = 1'b0, serial_mode_in = 1'b1, brake_when_off_in = 1'b0;
  logic dev_num_load_in = 1'b0, err_clear_in = 1'b0;
  logic [6:0] dev_num_in = 7'h00;
  logic [15:0] err_clear_mask_in = 16'h0000;
  wire logic [7:0] rx_byte_in;
  wire logic rx_valid_in, target_load_out, motor_enable_out, motor_brake_out;
  wire logic [11:0] target_out;
  wire logic [15:0] err_flags_out;
  wire logic [6:0] dev_num_out;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  logic [7:0] q[$];
  logic [11:0] t, exp_t;
  scp_parser DUT (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .rx_byte_in(rx_byte_in),
    .rx_valid_in(rx_valid_in), .crc_enable_in(crc_enable_in), .serial_mode_in(serial_mode_in),
    .brake_when_off_in(brake_when_off_in), .dev_num_load_in(dev_num_load_in),
    .dev_num_in(dev_num_in), .err_clear_in(err_clear_in), .err_clear_mask_in(err_clear_mask_in),
    .target_out(target_out), .target_load_out(target_load_out),
    .motor_enable_out(motor_enable_out), .motor_brake_out(motor_brake_out),
    .err_flags_out(err_flags_out), .dev_num_out(dev_num_out)
  );
  scp_host HOST (.sys_clk_in(sys_clk_in), .rx_byte_out(rx_byte_in), .rx_valid_out(rx_valid_in));
  always #10 sys_clk_in = ~sys_clk_in;
  // lsb-first crc with the reflected generator
  function automatic logic [6:0] crc7(input logic [7:0] m[$]);
    logic [7:0] c = 8'h00;
    foreach (m[i])
    begin
      c = c ^ m[i];
      repeat (8) c = c[0] ? (c ^ 8'h91) >> 1 : c >> 1;
    end
    return c[6:0];
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // bad flips the low crc bit so the packet must be dropped
  task automatic go(input logic bad);
    if (crc_enable_in) q.push_back({1'b0, crc7(q) ^ {6'h0, bad}});
    foreach (q[i]) HOST.send(q[i]);
    q.delete();
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic hires(input logic a, input logic [6:0] d, input logic [11:0] v, input logic bad);
    if (a) q = '{8'hAA, {1'b0, d}};
    q.push_back({~a, 2'b10, v[4:0]});
    q.push_back({1'b0, v[11:5]});
    go(bad);
  endtask
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // cycle ceiling well above the roughly 530 cycles the run needs
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(32'hd612001d));
    repeat (12) @(posedge sys_clk_in);
    #1 srst_in = 1'b0;
    chk("flags", 16'h1, err_flags_out);
    chk("devnum", 16'hB, dev_num_out);
    // corner and random targets, framings alternating, each then stopped
    for (int i = 0; i < 10; i++)
    begin
      t = i == 0 ? 12'hFFF : (i == 1 ? 12'h000 : 12'($urandom));
      hires(i[0], 7'h0B, t, 1'b0);
      chk("target", t, target_out);
      chk("await", 16'h0, err_flags_out[0]);
      chk("enable", 16'h1, motor_enable_out);
      brake_when_off_in = i[1];
      q = i[0] ? '{8'hAA, 8'h0B, 8'h7F} : '{8'hFF};
      go(1'b0);
      chk("await", 16'h1, err_flags_out[0]);
      chk("brake", i[1], motor_brake_out);
      chk("enable", 16'h0, motor_enable_out);
    end
    exp_t = t;
    hires(1'b1, 7'h0C, 12'h5A5, 1'b0);
    chk("target", exp_t, target_out);
    chk("flags", 16'h1, err_flags_out);
    dev_num_in = 7'h20 | 7'($urandom);
    dev_num_load_in = 1'b1;
    @(posedge sys_clk_in);
    #1 dev_num_load_in = 1'b0;
    chk("devnum", dev_num_in, dev_num_out);
    hires(1'b1, 7'h0B, 12'h321, 1'b0);
    chk("target", exp_t, target_out);
    hires(1'b1, dev_num_in, 12'h321, 1'b0);
    chk("target", 16'h321, target_out);
    serial_mode_in = 1'b0;
    q = '{8'hFF};
    go(1'b0);
    hires(1'b0, 7'h0, 12'h456, 1'b0);
    chk("target", 16'h321, target_out);
    chk("await", 16'h0, err_flags_out[0]);
    serial_mode_in = 1'b1;
    crc_enable_in = 1'b1;
    hires(1'b0, 7'h0, 12'hABC, 1'b0);
    chk("target", 16'hABC, target_out);
    hires(1'b0, 7'h0, 12'h111, 1'b1);
    chk("target", 16'hABC, target_out);
    chk("crcerr", 16'h1, err_flags_out[10]);
    HOST.send(8'hC5);
    q = '{8'hFF};
    go(1'b0);
    chk("proto", 16'h1, err_flags_out[11]);
    chk("await", 16'h1, err_flags_out[0]);
    err_clear_mask_in = 16'h0C01;
    err_clear_in = 1'b1;
    @(posedge sys_clk_in);
    #1 err_clear_in = 1'b0;
    chk("await", 16'h1, err_flags_out[0]);
    q = '{8'h83, 8'h01};
    chk("crc7", 16'h17, crc7(q));
    go(1'b0);
    chk("crcerr", 16'h0, err_flags_out[10]);
    final_report();
  end
endmodule // scp_parser_tb
bind scp_parser scp_parser_sva u_sva (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .rx_byte_in(rx_byte_in),
  .rx_valid_in(rx_valid_in), .crc_enable_in(crc_enable_in), .serial_mode_in(serial_mode_in),
  .brake_when_off_in(brake_when_off_in), .dev_num_load_in(dev_num_load_in),
  .dev_num_in(dev_num_in), .err_clear_in(err_clear_in), .err_clear_mask_in(err_clear_mask_in),
  .target_out(target_out), .target_load_out(target_load_out),
  .motor_enable_out(motor_enable_out), .motor_brake_out(motor_brake_out),
  .err_flags_out(err_flags_out), .dev_num_out(dev_num_out)
);
`default_nettype wire
